/* File: design/uhcs_consts.vh */
`ifndef UHCS_CONSTS_VH
`define UHCS_CONSTS_VH
// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define UHCS_OFF_VERSION  16'h1000
`define UHCS_OFF_MODE     16'h1004
`define UHCS_OFF_CMD      16'h1008
`define UHCS_OFF_EVENT    16'h100C
`define UHCS_SPEC_VERSION 8'h10
// ----------------------------------------------------------------------------
// functional state codes
// ----------------------------------------------------------------------------
`define UHCS_FS_BUS_RESET 2'h0
`define UHCS_FS_RESUME    2'h1
`define UHCS_FS_OPER      2'h2
`define UHCS_FS_SUSPEND   2'h3
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define UHCS_MODE_CONTROL_BULK_RATIO 0
`define UHCS_MODE_PLE  2
`define UHCS_MODE_ISO  3
`define UHCS_MODE_CLE  4
`define UHCS_MODE_BLE  5
`define UHCS_MODE_FS   6
`define UHCS_MODE_IR   8
`define UHCS_MODE_RWC  9
`define UHCS_MODE_RWE  10
`define UHCS_CMD_HCR   0
`define UHCS_CMD_CLF   1
`define UHCS_CMD_BLF   2
`define UHCS_CMD_OCR   3
`define UHCS_CMD_SOC   16
`define UHCS_EV_SO     0
`define UHCS_EV_WDH    1
`define UHCS_EV_SF     2
`define UHCS_EV_RD     3
`define UHCS_EV_UE     4
`define UHCS_EV_FNO    5
`define UHCS_EV_RHSC   6
`define UHCS_EV_OC     30
`define UHCS_EV_MIE    31
`define UHCS_EV_MASK   32'h4000007F
// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define UHCS_MODE_RESET  32'h00000000
`define UHCS_CMD_RESET   32'h00000000
`define UHCS_EVENT_RESET 32'h00000000
`define UHCS_CLK_NS      10
`define UHCS_FRAME_NS    1000000
`define UHCS_FRAME_CYC   (`UHCS_FRAME_NS / `UHCS_CLK_NS)
`define UHCS_SRST_MAX_NS 10000000
`define UHCS_SRST_CYC    4'h8
`define UHCS_RESP_OKAY   2'h0
`define UHCS_RESP_SLVERR 2'h2
`endif

/* File: design/uhcs_top.v */
`include "uhcs_consts.vh"
`default_nettype none
module uhcs_top #(
   parameter integer FRAME_CYC = `UHCS_FRAME_CYC  // cycles per frame
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [15:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [15:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        resume_pin,
   input  wire [31:0] irq_enable,
   input  wire        ctl_head_req,
   input  wire        bulk_head_req,
   input  wire        ctl_td_found,
   input  wire        bulk_td_found,
   input  wire        ctl_ed_served,
   input  wire        bulk_ed_served,
   input  wire        iso_ed_reached,
   input  wire        overrun_evt,
   input  wire        owner_done,
   input  wire        done_head_evt,
   input  wire        sys_error_evt,
   input  wire        frame_wrap_evt,
   input  wire        hub_change_evt,
   output wire        host_irq,
   output wire        smi_irq,
   output wire        remote_wakeup,
   output wire        port_reset,
   output wire        sof_pulse,
   output wire        periodic_go,
   output wire        iso_halt,
   output wire        ctl_start,
   output wire        bulk_start,
   output wire        serve_ctl
);
   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   // byte strobes to bit mask
   function [31:0] strb_mask;
      input [3:0] s;
      begin
         strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction
   // address to one-hot register select, zero when unmapped
   function [3:0] reg_sel;
      input [15:0] a;
      begin
         case ({a[15:2], 2'h0})
            `UHCS_OFF_VERSION: reg_sel = 4'h1;
            `UHCS_OFF_MODE:    reg_sel = 4'h2;
            `UHCS_OFF_CMD:     reg_sel = 4'h4;
            `UHCS_OFF_EVENT:   reg_sel = 4'h8;
            default:           reg_sel = 4'h0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   reg        awready_q, wready_q, bvalid_q, arready_q, rvalid_q; // bus handshakes
   reg        aw_full_q, w_full_q;       // write halves captured
   reg [15:0] awaddr_q;                  // held write address
   reg [31:0] wdata_q;                   // held write data
   reg [3:0]  wstrb_q;                   // held strobes
   reg [1:0]  bresp_q, rresp_q;          // responses
   reg [31:0] rdata_q;                   // read data
   reg        rwe_q, rwc_q, ir_q;        // wake enable, wake connected, routing
   reg [1:0]  fs_q;                      // functional state
   reg        ble_q, cle_q, iso_q, ple_q; // list enables
   reg [1:0]  control_bulk_ratio_q;                    // control to bulk ratio
   reg        hcr_q, clf_q, blf_q, ocr_q; // command bits
   reg        ocr_d1_q;                  // ocr delayed for edge
   reg [1:0]  soc_q;                     // overrun count
   reg [31:0] ev_q;                      // sticky event flags
   reg [3:0]  srst_cnt_q;                // soft reset progress
   reg [16:0] sof_cnt_q;                 // frame timer
   reg        sof_run_q;                 // frame timer running
   reg        ble_fr_q, cle_fr_q, iso_fr_q, ple_fr_q; // per frame enables
   reg [2:0]  ctl_cnt_q;                 // control eds served
   reg        rs1_q, rs2_q, rs3_q;       // resume pin sync and edge
   reg        host_irq_q, smi_q, wake_q, port_rst_q, sof_q; // outputs
   reg        per_go_q, iso_halt_q, ctl_start_q, bulk_start_q, serve_ctl_q;

   wire [3:0]  wsel   = reg_sel(awaddr_q);
   wire [3:0]  rsel   = reg_sel(s_axi_araddr);
   wire        wr_go  = aw_full_q & w_full_q & ~bvalid_q;
   wire [31:0] wm     = strb_mask(wstrb_q);
   wire [31:0] wd     = wdata_q & wm;
   wire        rd_go  = s_axi_arvalid & arready_q;
   wire        wr_mode = wr_go & wsel[1];
   wire        wr_cmd  = wr_go & wsel[2];
   wire        wr_ev   = wr_go & wsel[3];
   wire        srst_done = hcr_q & (srst_cnt_q == `UHCS_SRST_CYC);
   wire        sof_now = sof_run_q & (sof_cnt_q == FRAME_CYC[16:0] - 17'h1);
   wire        rd_rise = rs2_q & ~rs3_q;
   wire        oc_set  = ocr_q & ~ocr_d1_q;
   wire        ctl_take  = ctl_head_req & cle_fr_q & clf_q;
   wire        bulk_take = bulk_head_req & ble_fr_q & blf_q;
   wire [31:0] mode_rd;
   wire [31:0] cmd_rd;
   wire [31:0] ev_set;
   wire [31:0] pend;
   wire [1:0]  fs_wr;

   // register images, reserved bits zero
   assign mode_rd = {21'h0, rwe_q, rwc_q, ir_q, fs_q, ble_q, cle_q, iso_q, ple_q, control_bulk_ratio_q};
   assign cmd_rd  = {14'h0, soc_q, 12'h0, ocr_q, blf_q, clf_q, hcr_q};
   assign fs_wr   = (mode_rd[7:6] & ~wm[7:6]) | (wd[7:6]);

   // event sources into the sticky flags
   assign ev_set = ({31'h0, overrun_evt}                     << `UHCS_EV_SO)
                 | ({31'h0, done_head_evt}                   << `UHCS_EV_WDH)
                 | ({31'h0, sof_now}                         << `UHCS_EV_SF)
                 | ({31'h0, rd_rise}                         << `UHCS_EV_RD)
                 | ({31'h0, sys_error_evt}                   << `UHCS_EV_UE)
                 | ({31'h0, frame_wrap_evt}                  << `UHCS_EV_FNO)
                 | ({31'h0, hub_change_evt}                  << `UHCS_EV_RHSC)
                 | ({31'h0, oc_set}                          << `UHCS_EV_OC);
   assign pend = ev_q & irq_enable & `UHCS_EV_MASK;

   // ------------------------------------------------------------------------
   // bus write channel
   // ------------------------------------------------------------------------
   // address and data accepted in either order, answer after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `UHCS_RESP_OKAY;
         awaddr_q  <= 16'h0000;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid & awready_q) begin  // capture address
            awaddr_q  <= s_axi_awaddr;
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid & wready_q) begin    // capture data
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_go) begin                      // commit and answer
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == 4'h0) ? `UHCS_RESP_SLVERR : `UHCS_RESP_OKAY;
         end
         if (bvalid_q & s_axi_bready) begin    // response taken
            bvalid_q  <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // bus read channel
   // ------------------------------------------------------------------------
   // one-cycle read answer from current register images
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `UHCS_RESP_OKAY;
      end else if (rd_go) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= (rsel == 4'h0) ? `UHCS_RESP_SLVERR : `UHCS_RESP_OKAY;
         case (rsel)
            4'h1:    rdata_q <= {24'h0, `UHCS_SPEC_VERSION};
            4'h2:    rdata_q <= mode_rd;
            4'h4:    rdata_q <= cmd_rd;
            4'h8:    rdata_q <= ev_q;
            default: rdata_q <= 32'h00000000;
         endcase
      end else if (rvalid_q & s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // resume pin synchroniser
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
         rs3_q <= 1'b0;
      end else begin
         rs1_q <= resume_pin;
         rs2_q <= rs1_q;
         rs3_q <= rs2_q;
      end
   end

   // ------------------------------------------------------------------------
   // operating mode register
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin                       // hardware reset
         rwe_q  <= 1'b0;
         rwc_q  <= 1'b0;
         ir_q   <= 1'b0;
         fs_q   <= `UHCS_FS_BUS_RESET;
         ble_q  <= 1'b0;
         cle_q  <= 1'b0;
         iso_q  <= 1'b0;
         ple_q  <= 1'b0;
         control_bulk_ratio_q <= 2'h0;
      end else if (srst_done) begin             // soft reset keeps ir and rwc
         rwe_q  <= 1'b0;
         fs_q   <= `UHCS_FS_SUSPEND;
         ble_q  <= 1'b0;
         cle_q  <= 1'b0;
         iso_q  <= 1'b0;
         ple_q  <= 1'b0;
         control_bulk_ratio_q <= 2'h0;
      end else if (wr_mode) begin               // byte-lane merged write
         if (wm[8])  ir_q   <= wd[`UHCS_MODE_IR];
         if (wm[8])  rwc_q  <= wd[`UHCS_MODE_RWC];
         if (wm[8])  rwe_q  <= wd[`UHCS_MODE_RWE];
         if (wm[0])  ble_q  <= wd[`UHCS_MODE_BLE];
         if (wm[0])  cle_q  <= wd[`UHCS_MODE_CLE];
         if (wm[0])  iso_q  <= wd[`UHCS_MODE_ISO];
         if (wm[0])  ple_q  <= wd[`UHCS_MODE_PLE];
         if (wm[0])  control_bulk_ratio_q <= wd[1:0];
         fs_q <= fs_wr;
      end else if (rd_rise && fs_q == `UHCS_FS_SUSPEND) begin
         fs_q <= `UHCS_FS_RESUME;
      end
   end

   // ------------------------------------------------------------------------
   // command register and soft reset
   // ------------------------------------------------------------------------
   // sets win over hardware clears on the same edge
   always @(posedge aclk) begin
      if (!aresetn) begin
         hcr_q      <= 1'b0;
         clf_q      <= 1'b0;
         blf_q      <= 1'b0;
         ocr_q      <= 1'b0;
         ocr_d1_q   <= 1'b0;
         soc_q      <= 2'h0;
         srst_cnt_q <= 4'h0;
      end else if (srst_done) begin
         hcr_q      <= 1'b0;
         clf_q      <= 1'b0;
         blf_q      <= 1'b0;
         ocr_q      <= 1'b0;
         ocr_d1_q   <= 1'b0;
         soc_q      <= 2'h0;
         srst_cnt_q <= 4'h0;
      end else begin
         ocr_d1_q <= ocr_q;
         if (hcr_q)                             // soft reset in progress
            srst_cnt_q <= srst_cnt_q + 4'h1;
         if (wr_cmd & wd[`UHCS_CMD_HCR])
            hcr_q <= 1'b1;
         if (wr_cmd & wd[`UHCS_CMD_OCR])
            ocr_q <= 1'b1;
         else if (owner_done)
            ocr_q <= 1'b0;
         if ((wr_cmd & wd[`UHCS_CMD_CLF]) | ctl_td_found)
            clf_q <= 1'b1;
         else if (ctl_take)
            clf_q <= 1'b0;
         if ((wr_cmd & wd[`UHCS_CMD_BLF]) | bulk_td_found)
            blf_q <= 1'b1;
         else if (bulk_take)
            blf_q <= 1'b0;
         if (overrun_evt)
            soc_q <= soc_q + 2'h1;
      end
   end

   // ------------------------------------------------------------------------
   // event status register
   // ------------------------------------------------------------------------
   // write one clears, a same-cycle event wins
   always @(posedge aclk) begin
      if (!aresetn || srst_done) begin
         ev_q <= `UHCS_EVENT_RESET;
      end else if (wr_ev) begin
         ev_q <= ((ev_q & ~wd) | ev_set) & `UHCS_EV_MASK;
      end else begin
         ev_q <= (ev_q | ev_set) & `UHCS_EV_MASK;
      end
   end

   // ------------------------------------------------------------------------
   // frame timer
   // ------------------------------------------------------------------------
   // first marker one frame after entry to operational
   always @(posedge aclk) begin
      if (!aresetn || srst_done) begin
         sof_run_q <= 1'b0;
         sof_cnt_q <= 17'h0;
      end else if (wr_mode && fs_q != `UHCS_FS_OPER && fs_wr == `UHCS_FS_OPER) begin
         sof_run_q <= 1'b1;
         sof_cnt_q <= 17'h0;
      end else if (fs_q != `UHCS_FS_OPER) begin
         sof_run_q <= 1'b0;
         sof_cnt_q <= 17'h0;
      end else if (sof_now) begin
         sof_cnt_q <= 17'h0;
      end else if (sof_run_q) begin
         sof_cnt_q <= sof_cnt_q + 17'h1;
      end
   end

   // ------------------------------------------------------------------------
   // per-frame list enables and service ratio
   // ------------------------------------------------------------------------
   // enables sampled at each frame start
   always @(posedge aclk) begin
      if (!aresetn || srst_done) begin
         ble_fr_q  <= 1'b0;
         cle_fr_q  <= 1'b0;
         iso_fr_q  <= 1'b0;
         ple_fr_q  <= 1'b0;
         ctl_cnt_q <= 3'h0;
      end else begin
         if (sof_now) begin
            ble_fr_q <= ble_q;
            cle_fr_q <= cle_q;
            iso_fr_q <= iso_q;
            ple_fr_q <= ple_q;
         end
         if (bulk_ed_served)                    // bulk turn restarts count
            ctl_cnt_q <= 3'h0;
         else if (ctl_ed_served && ctl_cnt_q != 3'h4)
            ctl_cnt_q <= ctl_cnt_q + 3'h1;
      end
   end

   // ------------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         host_irq_q   <= 1'b0;
         smi_q        <= 1'b0;
         wake_q       <= 1'b0;
         port_rst_q   <= 1'b1;
         sof_q        <= 1'b0;
         per_go_q     <= 1'b0;
         iso_halt_q   <= 1'b0;
         ctl_start_q  <= 1'b0;
         bulk_start_q <= 1'b0;
         serve_ctl_q  <= 1'b0;
      end else begin
         // routed interrupt, ownership change always management
         host_irq_q <= irq_enable[`UHCS_EV_MIE] & ~ir_q
                       & (|pend[`UHCS_EV_RHSC:0]);
         smi_q      <= irq_enable[`UHCS_EV_MIE]
                       & ((ir_q & (|pend[`UHCS_EV_RHSC:0])) | pend[`UHCS_EV_OC]);
         wake_q       <= rwe_q & ev_q[`UHCS_EV_RD];
         port_rst_q   <= (fs_q == `UHCS_FS_BUS_RESET);
         sof_q        <= sof_now;
         per_go_q     <= ple_fr_q & (fs_q == `UHCS_FS_OPER);
         iso_halt_q   <= iso_ed_reached & ~iso_fr_q;
         ctl_start_q  <= ctl_take;
         bulk_start_q <= bulk_take;
         serve_ctl_q  <= cle_fr_q & (~ble_fr_q
                         | (ctl_cnt_q <= {1'b0, control_bulk_ratio_q}));
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign host_irq      = host_irq_q;
   assign smi_irq       = smi_q;
   assign remote_wakeup = wake_q;
   assign port_reset    = port_rst_q;
   assign sof_pulse     = sof_q;
   assign periodic_go   = per_go_q;
   assign iso_halt      = iso_halt_q;
   assign ctl_start     = ctl_start_q;
   assign bulk_start    = bulk_start_q;
   assign serve_ctl     = serve_ctl_q;
endmodule // uhcs_top
`default_nettype wire

/* File: tb/uhcs_assertions.sv */
`default_nettype none
module uhcs_assertions #(
   parameter integer FRAME_CYC = 20  // cycles per frame, from the top
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [31:0] irq_enable,
   input wire logic        ctl_head_req,
   input wire logic        bulk_head_req,
   input wire logic        iso_ed_reached,
   input wire logic        overrun_evt,
   input wire logic        host_irq,
   input wire logic        smi_irq,
   input wire logic        port_reset,
   input wire logic        sof_pulse,
   input wire logic        iso_halt,
   input wire logic        ctl_start,
   input wire logic        bulk_start
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   logic [16:0] gap_q;  // cycles since the last frame start
   logic        seen_q; // a frame start has been seen
   // frame gap counter, saturating
   always @(posedge aclk) begin
      if (!aresetn) begin
         gap_q  <= 17'h0;
         seen_q <= 1'b0;
      end else if (sof_pulse) begin
         gap_q  <= 17'h0;
         seen_q <= 1'b1;
      end else if (gap_q != 17'h1FFFF) begin
         gap_q <= gap_q + 17'h1;
      end
   end
   a_sof_period: assert property (disable iff (!aresetn) sof_pulse && seen_q |-> gap_q >= FRAME_CYC - 1)
      else $error("frame period too short");
   a_reset_state: assert property (!aresetn |=> port_reset && !host_irq && !smi_irq)
      else $error("outputs wrong after reset");
   a_release_state: assert property ($rose(aresetn) |-> port_reset)
      else $error("not in bus reset after release");
   a_sof_spacing: assert property (disable iff (!aresetn) sof_pulse |=> (!sof_pulse) [*8])
      else $error("frame start too soon");
   a_iso_cause: assert property (disable iff (!aresetn) iso_halt |-> $past(iso_ed_reached))
      else $error("halt without iso descriptor");
   a_ctl_cause: assert property (disable iff (!aresetn) ctl_start |-> $past(ctl_head_req))
      else $error("control start without request");
   a_bulk_cause: assert property (disable iff (!aresetn) bulk_start |-> $past(bulk_head_req))
      else $error("bulk start without request");
   a_overrun_irq: assert property (disable iff (!aresetn) overrun_evt && irq_enable[31] && irq_enable[0]
      |-> ##2 (host_irq || smi_irq)) else $error("overrun raised no interrupt");
   a_bus_reset_quiet: assert property (disable iff (!aresetn) port_reset [*2] |-> !sof_pulse)
      else $error("frame start in bus reset");
endmodule // uhcs_assertions
bind uhcs_top uhcs_assertions #(.FRAME_CYC(FRAME_CYC)) i_uhcs_assertions (.*);
`default_nettype wire

/* File: tb/uhcs_engine_model.sv */
`default_nettype none
module uhcs_engine_model (
   input wire logic aclk,
   input wire logic sof_pulse,
   input wire logic ctl_start,
   input wire logic bulk_start,
   input wire logic td_mode,
   output logic     ctl_head_req,
   output logic     bulk_head_req,
   output logic     ctl_td_found,
   output logic     bulk_td_found,
   output logic     ctl_ed_served,
   output logic     bulk_ed_served
);
   timeunit 1ns;
   timeprecision 1ps;
   // list walker: asks at each frame start, finds descriptors only in td mode
   always @(posedge aclk) begin
      ctl_head_req <= sof_pulse;
      bulk_head_req <= sof_pulse;
      ctl_td_found <= ctl_start & td_mode;
      bulk_td_found <= bulk_start & td_mode;
      ctl_ed_served <= ctl_start & td_mode;
      bulk_ed_served <= bulk_start & td_mode;
   end
endmodule // uhcs_engine_model
`default_nettype wire

/* File: tb/tb.sv */
`include "uhcs_consts.vh"
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] vr = `UHCS_OFF_VERSION, md = `UHCS_OFF_MODE, cm = `UHCS_OFF_CMD, ev = `UHCS_OFF_EVENT;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, td_mode;
   logic resume_pin, iso_ed_reached, overrun_evt, owner_done;
   logic done_head_evt, sys_error_evt, frame_wrap_evt, hub_change_evt;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, irq_enable, rd_d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] rd_r;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_irq, smi_irq;
   wire remote_wakeup, port_reset, sof_pulse, periodic_go, iso_halt, ctl_start, bulk_start, serve_ctl;
   wire ctl_head_req, bulk_head_req, ctl_td_found, bulk_td_found, ctl_ed_served, bulk_ed_served;
   int fails, tests_run, nstart;
   uhcs_top #(.FRAME_CYC(20)) i_uhcs_top (.*);
   uhcs_engine_model i_uhcs_engine_model (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) if (ctl_start === 1'b1) nstart++;
   task automatic end_of_test();
      if (fails == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic guard(input int n);
      if (n < 99) return;
      fails++;
      end_of_test();
   endtask
   // one bus access, write or read, held until answered
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1 && n < 99);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      guard(n);
   endtask
   task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
      xfer(1'b0, a, 32'h0);
      `CHK(nm, e, rd_d & m)
   endtask
   task automatic w_sof();
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (sof_pulse !== 1'b1 && n < 99);
      guard(n);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, td_mode} = 7'h00;
      {resume_pin, iso_ed_reached, overrun_evt, owner_done} = 4'h0;
      {done_head_evt, sys_error_evt, frame_wrap_evt, hub_change_evt} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
      s_axi_wstrb = 4'hF;
      irq_enable = 32'h80000001;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("port_reset", 1'b1, port_reset)
      xfer(1'b1, vr, 32'hFFFFFFFF);
      `CHK("ver_wresp", 2'h0, s_axi_bresp)
      xfer(1'b1, 16'h1010, 32'hFFFFFFFF);
      `CHK("unmapped_wresp", 2'h2, s_axi_bresp)
      rchk("version", vr, 32'h00000010);
      rchk("mode_reset", md, 32'h00000000);
      rchk("unmapped", 16'h1010, 32'h0);
      `CHK("unmapped_resp", 2'h2, rd_r)
      xfer(1'b1, md, 32'hFFFFF9BF);
      rchk("mode_fields", md, 32'h000001BF);
      `CHK("bus_reset_off", 1'b0, port_reset)
      xfer(1'b1, cm, 32'h00000006);
      w_sof();
      w_sof();
      rchk("filled_cleared", cm, 32'h0, 32'h6);
      `CHK("ctl_starts", 1, nstart)
      `CHK("serve_ctl", 1'b1, serve_ctl)
      `CHK("periodic_go", 1'b1, periodic_go)
      td_mode <= 1'b1;
      xfer(1'b1, cm, 32'h00000006);
      w_sof();
      w_sof();
      xfer(1'b1, cm, 32'h0);
      rchk("filled_kept", cm, 32'h6, 32'h6);
      overrun_evt <= 1'b1;
      repeat (5) @(posedge aclk);
      overrun_evt <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("smi_route", 1'b1, smi_irq)
      rchk("overrun_count", cm, 32'h00010000, 32'h00030000);
      rchk("overrun_flag", ev, 32'h1, 32'h1);
      xfer(1'b1, ev, 32'h00000041);
      rchk("flag_w1c", ev, 32'h0, 32'h41);
      xfer(1'b1, md, 32'h000000B7);
      w_sof();
      {iso_ed_reached, overrun_evt} <= 2'h3;
      @(posedge aclk);
      {iso_ed_reached, overrun_evt} <= 2'h0;
      @(posedge aclk);
      `CHK("iso_halt", 1'b1, iso_halt)
      repeat (2) @(posedge aclk);
      `CHK("host_route", 1'b1, host_irq)
      irq_enable <= 32'hC0000001;
      xfer(1'b1, cm, 32'h00000008);
      rchk("own_req", cm, 32'h8, 32'h8);
      rchk("own_flag", ev, 32'h40000000, 32'h40000000);
      `CHK("own_smi", 1'b1, smi_irq)
      owner_done <= 1'b1;
      @(posedge aclk);
      owner_done <= 1'b0;
      rchk("own_done", cm, 32'h0, 32'h8);
      xfer(1'b1, md, 32'h000004C0);
      resume_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      rchk("resume_move", md, 32'h00000440);
      `CHK("wakeup", 1'b1, remote_wakeup)
      xfer(1'b1, md, 32'h000003BF);
      xfer(1'b1, cm, 32'h00000001);
      rchk("reset_busy", cm, 32'h1, 32'h1);
      repeat (12) @(posedge aclk);
      rchk("reset_mode", md, 32'h000003C0);
      rchk("reset_cmd", cm, 32'h0, 32'h0003000F);
      `CHK("no_bus_reset", 1'b0, port_reset)
      `CHK("periodic_off", 1'b0, periodic_go)
      xfer(1'b1, md, 32'h000003B2);
      rchk("ratio_restored", md, 32'h000003B2);
      end_of_test();
   end
endmodule // tb
`default_nettype wire
